//--- design/qdl_port.sv
// Purpose: Serial load port of a quad 12-bit converter: shift, decode, load
// Assumes: link clock may also run while select is high; select and load pins
//          are asynchronous to SYS_CLK
// Notes:   Input and converter registers are not readable from the link
`timescale 1ns/1ps
`include "qdl_cfg.svh"

module qdl_port
	import qdl_pkg::*;
#(
	parameter int POR_TIME_NS = `QDL_POR_TIME_NS
)(
	// System clock, reset, enable
	input  wire logic                                    SYS_CLK,
	input  wire logic                                    RST,
	input  wire logic                                    CE,
	// Serial link from the host
	input  wire logic                                    LINK_SCLK,
	input  wire logic                                    SELECT_N,
	input  wire logic                                    SERIAL_IN,
	input  wire logic                                    LOAD_OUTPUTS_N,
	// Echo pin, two signals: data and output enable
	output logic                                         SERIAL_OUT,
	output logic                                         SERIAL_OUT_OE,
	// Converter codes and status
	output logic [`QDL_CHANNELS-1:0][`QDL_CODE_BITS-1:0] DAC_CODE,
	output logic                                         POR_BUSY
);
	// Longest time rounds down to whole cycles, never below one
	localparam int POR_CYCLES_RAW = POR_TIME_NS / `QDL_CLK_PERIOD_NS;
	localparam int POR_CYCLES     = (POR_CYCLES_RAW < 1) ? 1 : POR_CYCLES_RAW;
	localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);

	qdl_link_if lnk ();

	qdl_code_t  inp      [`QDL_CHANNELS];
	qdl_code_t  next_inp [`QDL_CHANNELS];
	qdl_code_t  next_dac [`QDL_CHANNELS];
	logic       sel_q1, sel_q2, sel_q3, sel_level, next_sel_level;
	logic       ld_q1, ld_q2, ld_q3, ld_level, next_ld_level;
	logic       echo_rise;
	logic       next_echo_rise;
	qdl_state_e state, next_state;
	logic [15:0] por_count;

	// Every check below runs on the system clock and sleeps through reset;
	// the link-domain shifter carries its own clocked checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	////////////////////////////////////////////////////////////////////////////
	// Channel one-hot decode, used for both register banks
	function automatic logic [`QDL_CHANNELS-1:0] chan_hot(input logic [1:0] addr);
		chan_hot = 4'h1 << addr;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Link-domain shifter
	qdl_shift u_shift (
		.link_clk  (LINK_SCLK),
		.select_n  (SELECT_N),
		.serial_in (SERIAL_IN),
		.lnk       (lnk.link)
	);

	assign lnk.echo_rise = echo_rise;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a change counts once the second and third flops agree
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sel_q1 <= 1'b1;
			sel_q2 <= 1'b1;
			sel_q3 <= 1'b1;
			ld_q1  <= 1'b1;
			ld_q2  <= 1'b1;
			ld_q3  <= 1'b1;
		end else if (CE) begin
			sel_q1 <= SELECT_N;
			sel_q2 <= sel_q1;
			sel_q3 <= sel_q2;
			ld_q1  <= LOAD_OUTPUTS_N;
			ld_q2  <= ld_q1;
			ld_q3  <= ld_q2;
		end
	end

	assign next_sel_level = (sel_q2 == sel_q3) ? sel_q3 : sel_level;
	assign next_ld_level  = (ld_q2 == ld_q3) ? ld_q3 : ld_level;

	// Select rising edge; the link word is frozen by then since the shifter
	// ignores edges with select high, so a plain multi-bit sample is safe
	wire       sel_rise = next_sel_level & ~sel_level;
	wire       commit   = sel_rise & (state == QDL_RUN);
	wire [1:0] addr     = lnk.word[`QDL_ADDR_MSB:`QDL_ADDR_LSB];
	wire [1:0] ctrl     = lnk.word[`QDL_CTRL_MSB:`QDL_CTRL_LSB];
	wire qdl_code_t code = lnk.word[`QDL_CODE_BITS-1:0];
	wire [`QDL_CHANNELS-1:0] hot = chan_hot(addr);

	////////////////////////////////////////////////////////////////////////////
	// Command decode
	wire is_special = (ctrl == `QDL_CTRL_SPECIAL);
	wire sp_all     = commit & is_special & (addr == `QDL_SP_LOAD_ALL);
	wire sp_fall    = commit & is_special & (addr == `QDL_SP_ECHO_FALL);
	wire sp_rise    = commit & is_special & (addr == `QDL_SP_ECHO_RISE);
	wire ld_in_cmd  = commit & ((ctrl == `QDL_CTRL_LOAD_IN) | (ctrl == `QDL_CTRL_LOAD_BOTH));
	wire ld_dac_cmd = commit & (ctrl == `QDL_CTRL_LOAD_BOTH);
	// Edge-select commands also move every input register to its converter
	wire upd_cmd    = commit & (ctrl == `QDL_CTRL_UPDATE) | sp_fall | sp_rise;
	// Load pin low keeps the converter registers transparent
	wire upd_all    = upd_cmd | ~ld_level;

	assign next_echo_rise = sp_rise ? 1'b1 : (sp_fall ? 1'b0 : echo_rise);

	// Register bank next values
	always_comb begin
		for (int i = 0; i < `QDL_CHANNELS; i++) begin
			next_inp[i] = ((ld_in_cmd & hot[i]) | sp_all) ? code : inp[i];
			if ((ld_dac_cmd & hot[i]) | sp_all) begin
				next_dac[i] = code;
			end else if (upd_all) begin
				next_dac[i] = next_inp[i];
			end else begin
				next_dac[i] = DAC_CODE[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-on hold: frames that end inside it are dropped
	assign next_state = (state == QDL_POR && por_count == POR_LAST) ? QDL_RUN : state;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state     <= QDL_POR;
			por_count <= 16'h0000;
			POR_BUSY  <= 1'b1;
		end else if (CE) begin
			state     <= next_state;
			por_count <= (state == QDL_POR) ? por_count + 16'h0001 : por_count;
			POR_BUSY  <= (next_state == QDL_POR);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Levels, mode and echo enable
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sel_level     <= 1'b1;
			ld_level      <= 1'b1;
			echo_rise     <= `QDL_ECHO_RISE_RST;
			SERIAL_OUT_OE <= 1'b0;
			SERIAL_OUT    <= 1'b1;
		end else if (CE) begin
			sel_level     <= next_sel_level;
			ld_level      <= next_ld_level;
			echo_rise     <= next_echo_rise;
			SERIAL_OUT_OE <= ~next_sel_level;
			// Released pin shows high; only the shift register is ever echoed
			SERIAL_OUT    <= next_sel_level | lnk.echo_bit;
		end
	end

	// The echo bit is taken from the link domain by that one flop only: it
	// adds at most one system cycle, far inside the host's half period, and a
	// rare metastable sample lands on a pin that nothing in here reads back

	////////////////////////////////////////////////////////////////////////////
	// Register banks
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			for (int i = 0; i < `QDL_CHANNELS; i++) begin
				inp[i]      <= `QDL_CODE_RESET;
				DAC_CODE[i] <= `QDL_CODE_RESET;
			end
		end else if (CE) begin
			for (int i = 0; i < `QDL_CHANNELS; i++) begin
				inp[i]      <= next_inp[i];
				DAC_CODE[i] <= next_dac[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence commit_s;
		CE && commit;
	endsequence

	load_input_a: assert property (commit_s and (ld_in_cmd && hot[0]) |=> inp[0] == $past(code))
		else $error("input register A missed its load");
	load_both_a: assert property (commit_s and (ld_dac_cmd && hot[3]) |=> DAC_CODE[3] == $past(code))
		else $error("converter register D missed direct load");
	load_pin_a: assert property ((CE && !ld_level) |=> DAC_CODE[1] == inp[1])
		else $error("load pin did not copy input to converter");
	por_gate_a: assert property ((state == QDL_POR) |-> !commit && POR_BUSY == (state == QDL_POR))
		else $error("frame committed during power-on hold");
	echo_enable_a: assert property ((CE && $fell(sel_level)) |-> SERIAL_OUT_OE)
		else $error("echo pin not enabled while selected");
	echo_release_a: assert property (!SERIAL_OUT_OE |-> SERIAL_OUT)
		else $error("released echo pin not high");
	edge_mode_a: assert property (CE && sp_rise |=> echo_rise ##1 (echo_rise || !CE || sp_fall))
		else $error("echo edge command not taken");
	no_stray_a: assert property ((CE && !commit && ld_level) |=> $stable(inp[2]))
		else $error("input register changed without a commit");
endmodule // qdl_port

//--- design/qdl_cfg.svh
// Purpose: Numeric constants of the quad converter serial load port
// Assumes: 100 MHz system clock
// Notes:   Field positions, command codes, reset values and timing constants only
`ifndef QDL_CFG_SVH
`define QDL_CFG_SVH

// Frame layout, most significant bit shifted first
`define QDL_WORD_BITS      16
`define QDL_ADDR_MSB       15
`define QDL_ADDR_LSB       14
`define QDL_CTRL_MSB       13
`define QDL_CTRL_LSB       12
`define QDL_CODE_BITS      12
`define QDL_CHANNELS       4

// Control field codes
`define QDL_CTRL_LOAD_IN   2'h0
`define QDL_CTRL_LOAD_BOTH 2'h1
`define QDL_CTRL_UPDATE    2'h2
`define QDL_CTRL_SPECIAL   2'h3

// Address field meaning under the special control code
`define QDL_SP_NOP         2'h0
`define QDL_SP_LOAD_ALL    2'h1
`define QDL_SP_ECHO_FALL   2'h2
`define QDL_SP_ECHO_RISE   2'h3

// Reset values
`define QDL_CODE_RESET     12'h000
`define QDL_ECHO_RISE_RST  1'b0

// Timing
`define QDL_CLK_PERIOD_NS  10
`define QDL_POR_TIME_NS    50000

`endif

//--- design/qdl_pkg.sv
// Purpose: Types shared by the serial load port modules
// Assumes: qdl_cfg.svh holds the numbers
// Notes:   Types only
`include "qdl_cfg.svh"

package qdl_pkg;
	typedef logic [`QDL_CODE_BITS-1:0] qdl_code_t;
	typedef logic [`QDL_WORD_BITS-1:0] qdl_word_t;
	typedef enum logic [0:0] {
		QDL_POR = 1'b0,
		QDL_RUN = 1'b1
	} qdl_state_e;
endpackage

//--- design/qdl_link_if.sv
// Purpose: Carrier between the link-clock shifter and the system-clock core
// Assumes: word is read by the core only while select is high
// Notes:   echo_rise crosses into the link domain through three flops
`timescale 1ns/1ps

interface qdl_link_if;
	import qdl_pkg::*;
	qdl_word_t word;
	logic      echo_bit;
	logic      echo_rise;

	modport link (output word, output echo_bit, input  echo_rise);
	modport core (input  word, input  echo_bit, output echo_rise);
endinterface

//--- design/qdl_shift.sv
// Purpose: Link-clock shift register and echo stage
// Assumes: select and serial data are launched by the host on its link clock
// Notes:   No reset here: only data lives in this domain
`timescale 1ns/1ps

module qdl_shift
	import qdl_pkg::*;
(
	// Link clock and frame signals
	input wire logic link_clk,
	input wire logic select_n,
	input wire logic serial_in,
	// Carrier to the core
	qdl_link_if.link lnk
);
	qdl_word_t word;
	logic      echo_fall;
	logic      rise_q1;
	logic      rise_q2;
	logic      rise_q3;
	logic      rise_level;
	logic      next_rise_level;

	////////////////////////////////////////////////////////////////////////////
	// Shift in on rising edges; edges seen with select high are dropped, so a
	// free-running clock near either select edge never counts
	always_ff @(posedge link_clk) begin
		if (!select_n) begin
			word <= {word[`QDL_WORD_BITS-2:0], serial_in};
		end
	end

	// Mode bit from the core, three flops since it comes from another clock;
	// a change counts once the second and third agree
	always_ff @(posedge link_clk) begin
		rise_q1    <= lnk.echo_rise;
		rise_q2    <= rise_q1;
		rise_q3    <= rise_q2;
		rise_level <= next_rise_level;
	end

	assign next_rise_level = (rise_q2 == rise_q3) ? rise_q3 : rise_level;

	// Falling-edge echo holds the outgoing bit for a full half period
	always_ff @(negedge link_clk) begin
		echo_fall <= word[`QDL_WORD_BITS-1];
	end

	assign lnk.word     = word;
	assign lnk.echo_bit = rise_level ? word[`QDL_WORD_BITS-1] : echo_fall;

	////////////////////////////////////////////////////////////////////////////
	// Upper bits stay unknown until the first frame has filled the register
	shift_in_a: assert property (@(posedge link_clk)
		!select_n |=> word[0] == $past(serial_in) &&
			word[`QDL_WORD_BITS-1:1] === $past(word[`QDL_WORD_BITS-2:0]))
		else $error("shift register did not take the serial input bit");
	idle_hold_a: assert property (@(posedge link_clk)
		select_n |=> word == $past(word))
		else $error("shift register moved while select was high");
	echo_rise_a: assert property (@(posedge link_clk)
		rise_level |-> lnk.echo_bit == word[`QDL_WORD_BITS-1])
		else $error("rising-edge echo does not show the leaving bit");
endmodule // qdl_shift

//--- sim/qdl_host.sv
// Purpose: Host model that drives frames on the serial link
// Assumes: link clock half period 80 ns, idle between frames except for the optional stray edges
// Notes:   Samples the echo pin just before and midway after each rising link edge
`timescale 1ns/1ps

module qdl_host
	import qdl_pkg::*;
(
	// Link pins
	output logic      LINK_SCLK,
	output logic      SELECT_N,
	output logic      SERIAL_IN,
	input  wire logic SERIAL_OUT,
	input  wire logic SERIAL_OUT_OE
);
	////////////////////////////////////////
	logic [31:0] cap;
	logic [31:0] cap_hi;
	// Released pin is pulled high, never left at the last bit
	wire         line = SERIAL_OUT_OE ? SERIAL_OUT : 1'b1;

	// Idle levels
	initial begin
		LINK_SCLK = 1'b0;
		SELECT_N = 1'b1;
		SERIAL_IN = 1'b1;
		cap = '0;
		cap_hi = '0;
	end

	// One frame; junk bits go first so only the last 16 count
	task automatic frame(input qdl_word_t w, input logic [7:0] junk, input int pre, input logic stray);
		logic [23:0] bits;
		bits = {junk, w};
		#37;
		if (stray) begin // Free-running edges while deselected
			repeat (2) begin
				SERIAL_IN = ~SERIAL_IN;
				#80 LINK_SCLK = 1'b1;
				#80 LINK_SCLK = 1'b0;
			end
			#40;
		end
		SELECT_N = 1'b0;
		#100; // Select leads the first edge
		for (int i = 15 + pre; i >= 0; i--) begin // MSB first
			SERIAL_IN = bits[i];
			#80;
			cap = {cap[30:0], line};
			LINK_SCLK = 1'b1;
			#40;
			cap_hi = {cap_hi[30:0], line};
			#40;
			LINK_SCLK = 1'b0;
			if (i == 8)
				#300; // Byte gap, select still low
		end
		#80;
		SELECT_N = 1'b1;
		SERIAL_IN = ~SERIAL_IN;
		#200;
	endtask
endmodule // qdl_host

//--- sim/qdl_port_tb_top.sv
// Purpose: Self-checking bench of the serial load port
// Assumes: short power-on hold of 500 cycles
// Notes:   Expected codes come from a register model of the bench
`timescale 1ns/1ps
`include "qdl_cfg.svh"

module qdl_port_tb_top;
	import qdl_pkg::*;
	////////////////////////////////////////
	localparam int POR_NS = 5000;
	logic            sys_clk, rst, load_n, ce, rise_m;
	wire             sclk, sel_n, sin, sout, soe, por_busy;
	wire [3:0][11:0] dac;
	int              error_cnt, compares, cyc, t0, settle;
	logic [31:0]     rnd;
	qdl_code_t       in_m[4], dac_m[4];
	qdl_word_t       prev;
	qdl_word_t       corner[9] = '{16'h0123, 16'h6456, 16'h2000, 16'h7a5c, 16'hf000, 16'h5800, 16'hb000,
		16'h3000, 16'hd9e1};

	qdl_port #(.POR_TIME_NS(POR_NS)) DUT (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .LINK_SCLK(sclk),
		.SELECT_N(sel_n), .SERIAL_IN(sin), .LOAD_OUTPUTS_N(load_n), .SERIAL_OUT(sout),
		.SERIAL_OUT_OE(soe), .DAC_CODE(dac), .POR_BUSY(por_busy));
	qdl_host host (.LINK_SCLK(sclk), .SELECT_N(sel_n), .SERIAL_IN(sin), .SERIAL_OUT(sout),
		.SERIAL_OUT_OE(soe));

	// Clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Register model; a held load pin makes converters follow
	task automatic model(input qdl_word_t w);
		logic [1:0] ch;
		logic [1:0] c;
		ch = w[15:14];
		c = w[13:12];
		if (c == `QDL_CTRL_LOAD_IN || c == `QDL_CTRL_LOAD_BOTH)
			in_m[ch] = w[11:0];
		if (c == `QDL_CTRL_LOAD_BOTH)
			dac_m[ch] = w[11:0];
		for (int i = 0; i < 4; i++) begin
			if (c == `QDL_CTRL_UPDATE || (c == `QDL_CTRL_SPECIAL && ch[1]) || !load_n)
				dac_m[i] = in_m[i];
			if (c == `QDL_CTRL_SPECIAL && ch == `QDL_SP_LOAD_ALL) begin
				in_m[i] = w[11:0];
				dac_m[i] = w[11:0];
			end
		end
		if (c == `QDL_CTRL_SPECIAL && ch[1] && rise_m != ch[0]) begin
			rise_m = ch[0];
			settle = 1;
		end
	endtask

	task automatic check_dac();
		for (int i = 0; i < 4; i++)
			check({4'h0, dac[i]}, {4'h0, dac_m[i]});
		check({14'h0, soe, sout}, 16'h1);
	endtask

	// Frame plus echo and register comparisons
	task automatic send(input qdl_word_t w, input int pre, input logic stray);
		@(posedge sys_clk);
		host.frame(w, rnd[7:0], pre, stray);
		// Both edge modes show the same bit just before a rising edge; midway
		// through the high phase the rising mode has already moved on
		if (pre == 0 && settle == 0) begin
			check(host.cap[15:0], prev);
			check(host.cap_hi[15:0], rise_m ? {prev[14:0], w[15]} : prev);
		end
		if (settle > 0)
			settle--;
		model(w);
		prev = w;
		rnd = lfsr(rnd);
		repeat (4) @(posedge sys_clk);
		check_dac();
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		{rst, load_n, ce, rise_m, settle, rnd} = {4'b1110, 32'd0, 32'h7a916436};
		{error_cnt, compares, cyc} = '0;
		in_m = '{default: '0};
		dac_m = '{default: '0};
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		t0 = cyc;
		@(negedge sys_clk);
		check({15'h0, por_busy}, 16'h1);
		host.frame(16'h5abc, 8'h00, 0, 1'b0);
		prev = 16'h5abc;
		check_dac();
		while (por_busy && cyc < t0 + 600)
			@(negedge sys_clk);
		check(16'(cyc - t0 >= POR_NS / 10 && cyc - t0 <= POR_NS / 10 + 2), 16'h1);
		$display("test power-on done");
		foreach (corner[k])
			send(corner[k], (k == 5) ? 8 : 0, k[0]);
		send(16'h8abc, 0, 1'b0);
		// Enable low freezes the load pin synchroniser, so nothing may move yet
		ce <= 1'b0;
		load_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		check_dac();
		ce <= 1'b1;
		repeat (6) @(posedge sys_clk);
		load_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		dac_m = in_m;
		check_dac();
		$display("test corners done");
		repeat (24) begin
			load_n <= |rnd[23:22];
			send(rnd[15:0], rnd[16] ? int'(rnd[19:17]) : 0, rnd[20]);
		end
		$display("test random done");
		report_and_stop();
	end
endmodule // qdl_port_tb_top
